// >>> core/swr_pkg.sv
// Shared timing, command and state definitions for the single-wire link
`default_nettype none
package swr_pkg;
	localparam int CLK_NS    = 50;
	localparam int CNT_W     = 12;
	// Link times in ns
	localparam int RESET_NS  = 48000;
	localparam int DSCHG_NS  = 150000;
	localparam int RRT_NS    = 8000;
	localparam int DRR_NS    = 1000;
	localparam int MSDR_NS   = 2000;
	localparam int DACK_NS   = 8000;
	localparam int HTSS_NS   = 150000;
	localparam int STDET_NS  = 100000;
	localparam int BIT_NS    = 15000;
	localparam int LOW1_NS   = 1000;
	localparam int LOW0_NS   = 8000;
	localparam int SMP_NS    = 3000;
	localparam int RD_NS     = 1000;
	localparam int MRS_NS    = 2000;
	localparam int HLD0_NS   = 4000;
	// Cycle counts, least times rounded up
	localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int DSCHG_CYC = (DSCHG_NS + CLK_NS - 1) / CLK_NS;
	localparam int RRT_CYC   = (RRT_NS + CLK_NS - 1) / CLK_NS;
	localparam int DRR_CYC   = (DRR_NS + CLK_NS - 1) / CLK_NS;
	localparam int MSDR_CYC  = (MSDR_NS + CLK_NS - 1) / CLK_NS;
	localparam int DACK_CYC  = (DACK_NS + CLK_NS - 1) / CLK_NS;
	localparam int HTSS_CYC  = (HTSS_NS + CLK_NS - 1) / CLK_NS;
	localparam int STDET_CYC = (STDET_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT_CYC   = (BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOW1_CYC  = (LOW1_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOW0_CYC  = (LOW0_NS + CLK_NS - 1) / CLK_NS;
	localparam int SMP_CYC   = (SMP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC    = (RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int MRS_CYC   = MRS_NS / CLK_NS;
	localparam int HLD0_CYC  = (HLD0_NS + CLK_NS - 1) / CLK_NS;
	localparam int BYTE_FRM  = 9;
	// Host commands
	typedef enum logic [2:0] {
		CMD_RESET  = 3'h0,
		CMD_DSCHG  = 3'h1,
		CMD_DISC   = 3'h2,
		CMD_START  = 3'h3,
		CMD_WRITE  = 3'h4,
		CMD_READ   = 3'h5
	} swr_cmd_e;
	// Device states
	typedef enum logic [2:0] {
		ST_DISC  = 3'h1,
		ST_READY = 3'h2,
		ST_BUSY  = 3'h4
	} swr_dst_e;
	typedef enum logic [1:0] {
		HS_IDLE = 2'h1,
		HS_RUN  = 2'h2
	} swr_hst_e;
	typedef struct packed {
		logic [CNT_W-1:0] low;
		logic [CNT_W-1:0] total;
		logic [CNT_W-1:0] smp;
		logic             smp_en;
	} swr_frame_s;
endpackage
`default_nettype wire

// >>> core/swr_link_if.sv
// Open-drain single-wire link between host and device ends
`timescale 1ns/10ps
`default_nettype none
interface swr_link_if;
	logic host_oe;
	logic host_out;
	logic dev_oe;
	logic dev_out;
	logic sio;
	// Pulled high unless an end drives low
	assign sio = !((host_oe && !host_out) || (dev_oe && !dev_out));
	modport host (output host_oe, output host_out, input sio);
	modport dev  (output dev_oe, output dev_out, input sio);
endinterface
`default_nettype wire

// >>> core/swr_device.sv
// Device end: frame timing, reset, discovery answer and byte framing
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - bytes are eight bits, MSB first
// - only the master opens each bit frame
// - first byte after start is opcode-address
// - ninth frame carries acknowledge from receiver
// - master sends byte frames without pauses
// - symbols told apart by low duration
// - reset and discovery kept out of stream
// - idle device resets on reset-length low
// - busy device resets on discharge-length low
// - master requests discovery before any read or write
// - master waits recovery time before discovery
// - master holds discovery request low
// - device holds line for discovery ack time
// - master samples discovery at set time
// - master leaves start high before command
// - reset clears address pointer to zero
// - busy device ignores frames except discharge
// - input bit decoded from low length
// - start and stop are long high times
// - output zero held low for hold time
module swr_device import swr_pkg::*; #(
	parameter int RST_LOW  = RESET_CYC,
	parameter int DSC_LOW  = DSCHG_CYC,
	parameter int ACK_HOLD = DACK_CYC,
	parameter int SMP_AT   = SMP_CYC,
	parameter int OUT_HOLD = HLD0_CYC,
	parameter int ST_HIGH  = STDET_CYC
) (
	input  wire logic       CORE_CLK,    // System clock
	input  wire logic       RESET_N,     // Sync reset, active low
	swr_link_if.dev         LINK,        // Single-wire link
	input  wire logic       TX_EN,       // Next byte is sent to master
	input  wire logic [7:0] TX_DATA,     // Byte to send
	input  wire logic       RX_NACK,     // Refuse received byte
	input  wire logic       BUSY_REQ,    // Start internal operation
	input  wire logic       BUSY_DONE,   // Internal operation ended
	output logic [7:0]      RX_DATA,     // Received byte
	output logic            RX_VALID,    // Received byte pulse
	output logic            RX_FIRST,    // Byte was opcode-address
	output logic            START_STOP,  // Start or stop pulse
	output logic            MST_ACK,     // Master acknowledged
	output logic            MST_ACK_VLD, // Master ack pulse
	output logic [7:0]      ADDR_PTR,    // Internal address pointer
	output logic            LINK_READY,  // Discovery answered
	output logic            BUSY         // Ignoring the line
);
	localparam logic [CNT_W-1:0] RST_C  = CNT_W'(RST_LOW);
	localparam logic [CNT_W-1:0] DSC_C  = CNT_W'(DSC_LOW);
	localparam logic [CNT_W-1:0] SMP_C  = CNT_W'(SMP_AT);
	localparam logic [CNT_W-1:0] ST_C   = CNT_W'(ST_HIGH);
	localparam logic [CNT_W-1:0] ACK_C  = CNT_W'(ACK_HOLD - 1);
	localparam logic [CNT_W-1:0] HLD_C  = CNT_W'(OUT_HOLD - 1);
	localparam logic [CNT_W-1:0] CNT_MX = '1;

	logic             sio_s1_r;
	logic             sio_s2_r;
	logic             sio_d_r;
	logic [CNT_W-1:0] low_cnt_r;
	logic [CNT_W-1:0] high_cnt_r;
	logic [CNT_W-1:0] drv_cnt_r;
	logic             drv_r;
	logic             drv_frm_r;
	swr_dst_e         state_r;
	logic             framed_r;
	logic             first_r;
	logic             tx_byte_r;
	logic [3:0]       bit_idx_r;
	logic [7:0]       shf_r;
	logic             fall;
	logic             rise;
	logic             rst_hit;
	logic             in_bit;
	logic             tx_now;
	logic             tx_bit;
	logic             out_low;

	////////////////////////////////////////////////////////////////////////
	// Line sampling and pulse timing
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			sio_s1_r <= 1'b1;
			sio_s2_r <= 1'b1;
			sio_d_r  <= 1'b1;
		end else begin
			sio_s1_r <= LINK.sio;
			sio_s2_r <= sio_s1_r;
			sio_d_r  <= sio_s2_r;
		end
	end

	assign fall = sio_d_r && !sio_s2_r;
	assign rise = !sio_d_r && sio_s2_r;

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			low_cnt_r  <= '0;
			high_cnt_r <= '0;
		end else begin
			// Low timer restarts on each falling edge
			low_cnt_r  <= sio_s2_r ? '0 :
				(low_cnt_r == CNT_MX ? low_cnt_r : low_cnt_r + 1'b1);
			high_cnt_r <= !sio_s2_r ? '0 :
				(high_cnt_r == CNT_MX ? high_cnt_r : high_cnt_r + 1'b1);
		end
	end

	// Busy: only the discharge length counts
	assign rst_hit = (state_r != ST_BUSY && low_cnt_r == RST_C) ||
		(low_cnt_r == DSC_C);
	assign in_bit  = low_cnt_r < SMP_C;
	assign tx_now  = (bit_idx_r == 4'h0) ? (TX_EN && !first_r) : tx_byte_r;
	assign tx_bit  = (bit_idx_r == 4'h0) ? TX_DATA[7] : shf_r[7];
	assign out_low = (bit_idx_r < 4'h8) ? (tx_now && !tx_bit) :
		(!tx_byte_r && !RX_NACK);

	////////////////////////////////////////////////////////////////////////
	// Link drive
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			drv_r     <= 1'b0;
			drv_cnt_r <= '0;
			drv_frm_r <= 1'b0;
		end else if (rst_hit) begin
			drv_r     <= 1'b0;
			drv_frm_r <= 1'b0;
		end else if (drv_r) begin
			drv_cnt_r <= drv_cnt_r - 1'b1;
			if (drv_cnt_r == '0)
				drv_r <= 1'b0;
		end else if (fall && state_r == ST_DISC) begin
			drv_r     <= 1'b1;
			drv_cnt_r <= ACK_C;
		end else if (fall && state_r == ST_READY && framed_r) begin
			drv_frm_r <= out_low || (bit_idx_r < 4'h8 && tx_now);
			if (out_low) begin
				drv_r     <= 1'b1;
				drv_cnt_r <= HLD_C;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		LINK.dev_oe  <= drv_r && RESET_N;
		LINK.dev_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Device state and byte framing
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			state_r <= ST_DISC;
		end else if (rst_hit) begin
			state_r <= ST_DISC;
		end else begin
			unique case (state_r)
			ST_DISC: begin
				if (drv_r && drv_cnt_r == '0)
					state_r <= ST_READY;
			end
			ST_READY: begin
				if (BUSY_REQ)
					state_r <= ST_BUSY;
			end
			ST_BUSY: begin
				if (BUSY_DONE)
					state_r <= ST_READY;
			end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		RX_VALID    <= 1'b0;
		START_STOP  <= 1'b0;
		MST_ACK_VLD <= 1'b0;
		if (!RESET_N || rst_hit) begin
			framed_r  <= 1'b0;
			first_r   <= 1'b0;
			tx_byte_r <= 1'b0;
			bit_idx_r <= '0;
			shf_r     <= '0;
			ADDR_PTR  <= '0;
			if (!RESET_N) begin
				RX_DATA  <= '0;
				RX_FIRST <= 1'b0;
				MST_ACK  <= 1'b0;
			end
		end else if (state_r != ST_READY) begin
			framed_r <= 1'b0;
		end else if (high_cnt_r == ST_C) begin
			START_STOP <= 1'b1;
			framed_r   <= 1'b1;
			first_r    <= 1'b1;
			bit_idx_r  <= '0;
		end else if (framed_r && fall && bit_idx_r == 4'h0) begin
			tx_byte_r <= tx_now;
			shf_r     <= tx_now ? TX_DATA : shf_r;
		end else if (framed_r && rise) begin
			// Frame ends on release; low length picks the symbol
			if (bit_idx_r < 4'h8) begin
				shf_r     <= tx_byte_r ? {shf_r[6:0], 1'b0} :
					{shf_r[6:0], in_bit};
				bit_idx_r <= bit_idx_r + 1'b1;
				if (bit_idx_r == 4'h7 && !tx_byte_r) begin
					RX_DATA  <= {shf_r[6:0], in_bit};
					RX_FIRST <= first_r;
					RX_VALID <= 1'b1;
				end
			end else begin
				bit_idx_r <= '0;
				first_r   <= 1'b0;
				if (tx_byte_r) begin
					MST_ACK     <= !in_bit;
					MST_ACK_VLD <= 1'b1;
				end
				if (!first_r && !drv_frm_r || tx_byte_r || !RX_NACK && !first_r)
					ADDR_PTR <= ADDR_PTR + 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			LINK_READY <= 1'b0;
			BUSY       <= 1'b0;
		end else begin
			LINK_READY <= state_r != ST_DISC;
			BUSY       <= state_r == ST_BUSY;
		end
	end
endmodule
`default_nettype wire

// >>> core/swr_host.sv
// Host end: generates reset, discovery, start/stop and byte frames
`timescale 1ns/10ps
`default_nettype none
module swr_host import swr_pkg::*; (
	input  wire logic       CORE_CLK,  // System clock
	input  wire logic       RESET_N,   // Sync reset, active low
	swr_link_if.host        LINK,      // Single-wire link
	input  wire logic [2:0] CMD,       // Command code
	input  wire logic       CMD_VALID, // Command request
	input  wire logic [7:0] WR_DATA,   // Byte to write
	input  wire logic       RD_ACK,    // Acknowledge after read
	output logic            CMD_READY, // Ready for a command
	output logic [7:0]      RD_DATA,   // Byte read
	output logic            ACK_OK,    // Low seen in ack or discovery
	output logic            DONE,      // Command finished pulse
	output logic            FOUND      // Device answered discovery
);
	logic             sio_s1_r;
	logic             sio_s2_r;
	swr_hst_e         state_r;
	swr_cmd_e         op_r;
	logic [CNT_W-1:0] cnt_r;
	logic [3:0]       idx_r;
	logic [7:0]       shf_r;
	logic             ack_r;
	swr_frame_s       frm_r;
	swr_frame_s       plan;
	swr_frame_s       plan0;
	logic [3:0]       nfrm;

	// Timing of one frame for a command and frame index
	function automatic swr_frame_s frame_plan(swr_cmd_e op, logic [3:0] idx,
			logic bit7, logic ack);
		swr_frame_s f;
		f = '{low: '0, total: CNT_W'(BIT_CYC), smp: CNT_W'(MRS_CYC),
			smp_en: 1'b0};
		unique case (op)
		CMD_RESET: begin
			f.low   = CNT_W'(RESET_CYC);
			f.total = CNT_W'(RESET_CYC + RRT_CYC);
		end
		CMD_DSCHG: begin
			f.low   = CNT_W'(DSCHG_CYC);
			f.total = CNT_W'(DSCHG_CYC + RRT_CYC);
		end
		CMD_DISC: begin
			f.low    = CNT_W'(DRR_CYC);
			f.smp    = CNT_W'(MSDR_CYC);
			f.smp_en = 1'b1;
			f.total  = CNT_W'(DACK_CYC + HTSS_CYC);
		end
		CMD_START: begin
			f.total = CNT_W'(HTSS_CYC);
		end
		CMD_WRITE: begin
			f.smp_en = idx == 4'h8;
			f.low    = (idx == 4'h8) ? CNT_W'(RD_CYC) :
				(bit7 ? CNT_W'(LOW1_CYC) : CNT_W'(LOW0_CYC));
		end
		CMD_READ: begin
			f.smp_en = idx != 4'h8;
			f.low    = (idx != 4'h8) ? CNT_W'(RD_CYC) :
				(ack ? CNT_W'(LOW0_CYC) : CNT_W'(LOW1_CYC));
		end
		default: f.total = CNT_W'(1);
		endcase
		return f;
	endfunction

	assign plan = frame_plan(op_r, idx_r + 1'b1, shf_r[6], ack_r);
	// First frame of the command on the inputs
	assign plan0 = frame_plan(swr_cmd_e'(CMD), 4'h0, WR_DATA[7], RD_ACK);
	assign nfrm = (op_r == CMD_WRITE || op_r == CMD_READ) ?
		4'(BYTE_FRM) : 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Line sampling
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			sio_s1_r <= 1'b1;
			sio_s2_r <= 1'b1;
		end else begin
			sio_s1_r <= LINK.sio;
			sio_s2_r <= sio_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_ff @(posedge CORE_CLK) begin
		DONE <= 1'b0;
		if (!RESET_N) begin
			state_r      <= HS_IDLE;
			op_r         <= CMD_START;
			cnt_r        <= '0;
			idx_r        <= '0;
			shf_r        <= '0;
			ack_r        <= 1'b0;
			frm_r        <= '0;
			CMD_READY    <= 1'b1;
			RD_DATA      <= '0;
			ACK_OK       <= 1'b0;
			FOUND        <= 1'b0;
			LINK.host_oe <= 1'b0;
		end else begin
			unique case (state_r)
			HS_IDLE: begin
				if (CMD_VALID && CMD_READY) begin
					if (CMD > 3'h5 || (CMD >= 3'h4 && !FOUND)) begin
						// Data commands before discovery finish at once with no frames
						DONE   <= 1'b1;
						ACK_OK <= 1'b0;
					end else begin
						op_r      <= swr_cmd_e'(CMD);
						shf_r     <= WR_DATA;
						ack_r     <= RD_ACK;
						idx_r     <= '0;
						cnt_r     <= '0;
						frm_r     <= plan0;
						LINK.host_oe <= plan0.low != '0;
						CMD_READY <= 1'b0;
						state_r   <= HS_RUN;
						if (CMD == 3'h0 || CMD == 3'h1)
							FOUND <= 1'b0;
					end
				end
			end
			HS_RUN: begin
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r + 1'b1 == frm_r.low)
					LINK.host_oe <= 1'b0;
				if (frm_r.smp_en && cnt_r == frm_r.smp) begin
					if (idx_r == 4'h8 || op_r == CMD_DISC) begin
						ACK_OK <= !sio_s2_r;
						if (op_r == CMD_DISC)
							FOUND <= !sio_s2_r;
					end else begin
						RD_DATA <= {RD_DATA[6:0], sio_s2_r};
					end
				end
				if (cnt_r + 1'b1 == frm_r.total) begin
					if (idx_r + 1'b1 == nfrm) begin
						state_r   <= HS_IDLE;
						CMD_READY <= 1'b1;
						DONE      <= 1'b1;
					end else begin
						// Next frame follows at once
						idx_r        <= idx_r + 1'b1;
						shf_r        <= {shf_r[6:0], 1'b0};
						cnt_r        <= '0;
						frm_r        <= plan;
						LINK.host_oe <= plan.low != '0;
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		LINK.host_out <= 1'b0;
	end
endmodule
`default_nettype wire

// >>> bench/swr_chk.sv
// Concurrent checks on the single-wire link signals
`timescale 1ns/10ps
`default_nettype none
module swr_chk import swr_pkg::*; (
	input wire logic CORE_CLK, // System clock
	input wire logic RESET_N,  // Sync reset, active low
	input wire logic host_oe,  // Host pulls low
	input wire logic host_out, // Host level when driving
	input wire logic dev_oe,   // Device pulls low
	input wire logic dev_out,  // Device level when driving
	input wire logic sio       // Wire level
);
	logic [CNT_W-1:0] h_lo_r;
	logic [CNT_W-1:0] h_hi_r;
	logic [CNT_W-1:0] d_lo_r;
	logic             long_r;
	logic             disc_r;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	////////////////////////////////////////////////////////////////////////
	// Low and high run lengths
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			h_lo_r <= '0;
			h_hi_r <= '0;
			d_lo_r <= '0;
		end else begin
			h_lo_r <= host_oe ? h_lo_r + 1'b1 : '0;
			h_hi_r <= host_oe ? '0 : (&h_hi_r ? h_hi_r : h_hi_r + 1'b1);
			d_lo_r <= dev_oe ? d_lo_r + 1'b1 : '0;
		end
	end

	// Last host pulse was a reset, last device pulse a discovery answer
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			long_r <= 1'b0;
			disc_r <= 1'b0;
		end else begin
			if (host_oe && h_lo_r == '0)
				long_r <= 1'b0;
			else if (host_oe && h_lo_r >= RESET_CYC - 2)
				long_r <= 1'b1;
			if (host_oe && h_lo_r == '0)
				disc_r <= 1'b0;
			// Answer inside a reset pulse ends while the host still pulls
			else if (!dev_oe && !host_oe && d_lo_r >= DACK_CYC - 8)
				disc_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_dev_follows: assert property ($rose(dev_oe) |-> host_oe
		&& h_lo_r >= 1 && h_lo_r <= 12) else $error("device opened a frame");
	a_drive_low: assert property (!(host_oe && host_out)
		&& !(dev_oe && dev_out)) else $error("open-drain driven high");
	a_dev_hold_len: assert property ($fell(dev_oe) |->
		(d_lo_r >= HLD0_CYC - 8 && d_lo_r <= HLD0_CYC + 1)
		|| (d_lo_r >= DACK_CYC - 8 && d_lo_r <= DACK_CYC + 1))
		else $error("device low hold length wrong");
	a_ack_bounded: assert property (d_lo_r <= DACK_CYC + 1)
		else $error("device holds line too long");
	a_host_low_len: assert property ($fell(host_oe) |->
		(h_lo_r >= LOW1_CYC - 1 && h_lo_r <= LOW1_CYC + 2)
		|| (h_lo_r >= LOW0_CYC - 1 && h_lo_r <= LOW0_CYC + 2)
		|| (h_lo_r >= RESET_CYC - 1 && h_lo_r <= RESET_CYC + 2)
		|| (h_lo_r >= DSCHG_CYC - 1 && h_lo_r <= DSCHG_CYC + 2))
		else $error("host low length wrong");
	a_reset_quiet: assert property ($fell(host_oe) && long_r
		|-> !dev_oe [*8]) else $error("reset pulse answered");
	a_recovery_wait: assert property ($rose(host_oe) && long_r
		|-> h_hi_r >= RRT_CYC - 1) else $error("recovery too short");
	a_start_gap: assert property ($rose(host_oe) && disc_r
		|-> h_hi_r >= HTSS_CYC - 1) else $error("no start after discovery");
endmodule
`default_nettype wire

// >>> bench/swr_tb.sv
// Testbench joining host and device ends over the single-wire link
`timescale 1ns/10ps
`default_nettype none
module swr_tb import swr_pkg::*;;
	logic       clk;
	logic       rst_n;
	logic [2:0] cmd;
	logic       cmd_vld;
	logic [7:0] wr_data;
	logic       rd_ack;
	logic       tx_en;
	logic [7:0] tx_data;
	logic       rx_nack;
	logic       busy_req;
	logic       busy_done;
	logic       cmd_rdy;
	logic [7:0] rd_data;
	logic       ack_ok;
	logic       done;
	logic       found;
	logic [7:0] rx_data;
	logic       rx_vld;
	logic       rx_first;
	logic       st_sp;
	logic       m_ack;
	logic       m_ack_vld;
	logic [7:0] addr_ptr;
	logic       lnk_rdy;
	logic       busy;
	int         error_cnt;
	int         checks_done;
	int         rx_cnt;
	int         ss_cnt;
	int         mav_cnt;
	int         n0;
	logic [7:0] wb [4] = '{8'hb5, 8'h80, 8'h01, 8'h3c};
	logic [7:0] rb [2] = '{8'ha6, 8'h59};

	swr_link_if swr_link_if_i ();
	swr_host swr_host_i (.CORE_CLK(clk), .RESET_N(rst_n),
		.LINK(swr_link_if_i.host), .CMD(cmd), .CMD_VALID(cmd_vld),
		.WR_DATA(wr_data), .RD_ACK(rd_ack), .CMD_READY(cmd_rdy),
		.RD_DATA(rd_data), .ACK_OK(ack_ok), .DONE(done), .FOUND(found));
	swr_device swr_device_i (.CORE_CLK(clk), .RESET_N(rst_n),
		.LINK(swr_link_if_i.dev), .TX_EN(tx_en), .TX_DATA(tx_data),
		.RX_NACK(rx_nack), .BUSY_REQ(busy_req), .BUSY_DONE(busy_done),
		.RX_DATA(rx_data), .RX_VALID(rx_vld), .RX_FIRST(rx_first),
		.START_STOP(st_sp), .MST_ACK(m_ack), .MST_ACK_VLD(m_ack_vld),
		.ADDR_PTR(addr_ptr), .LINK_READY(lnk_rdy), .BUSY(busy));
	swr_chk swr_chk_i (.CORE_CLK(clk), .RESET_N(rst_n),
		.host_oe(swr_link_if_i.host_oe), .host_out(swr_link_if_i.host_out),
		.dev_oe(swr_link_if_i.dev_oe), .dev_out(swr_link_if_i.dev_out),
		.sio(swr_link_if_i.sio));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Count one-cycle pulses from the device end
	always @(posedge clk) begin
		if (rx_vld === 1'b1)
			rx_cnt <= rx_cnt + 1;
		if (st_sp === 1'b1)
			ss_cnt <= ss_cnt + 1;
		if (m_ack_vld === 1'b1)
			mav_cnt <= mav_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
		input string msg);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s: %h vs %h", $time, msg, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Issue one host command and wait for its completion pulse
	task automatic run(input logic [2:0] c, input logic [7:0] d,
		input logic a);
		int n;
		@(negedge clk);
		cmd = c;
		wr_data = d;
		rd_ack = a;
		cmd_vld = 1'b1;
		n = 0;
		while (cmd_rdy !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		if (n >= 8) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t command %0d not taken", $time, c);
			end_sim();
		end
		@(negedge clk);
		cmd_vld = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 4000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t command %0d hung", $time, c);
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		cmd = CMD_RESET;
		cmd_vld = 1'b0;
		wr_data = 8'h00;
		rd_ack = 1'b0;
		tx_en = 1'b0;
		tx_data = 8'h00;
		rx_nack = 1'b0;
		busy_req = 1'b0;
		busy_done = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		chk(addr_ptr, 8'h00, "pointer at reset");
		run(CMD_WRITE, 8'ha5, 1'b0);
		chk({7'h0, ack_ok}, 8'h00, "write before discovery");
		run(CMD_RESET, 8'h00, 1'b0);
		chk(8'(rx_cnt + ss_cnt), 8'h00, "reset decoded");
		run(CMD_DISC, 8'h00, 1'b0);
		chk({6'h0, found, lnk_rdy}, 8'h03, "discovery");
		chk({7'h0, ack_ok}, 8'h01, "presence sample");
		run(CMD_START, 8'h00, 1'b0);
		chk(8'(ss_cnt > 0), 8'h01, "start seen");
		foreach (wb[i]) begin
			run(CMD_WRITE, wb[i], 1'b0);
			chk(rx_data, wb[i], "received byte");
			chk({6'h0, rx_first, ack_ok}, {6'h0, i == 0, 1'b1}, "ack");
		end
		chk(8'(rx_cnt), 8'h04, "byte count");
		chk(addr_ptr, 8'h03, "pointer step");
		@(negedge clk);
		rx_nack = 1'b1;
		run(CMD_WRITE, 8'h6e, 1'b0);
		chk({7'h0, ack_ok}, 8'h00, "refused byte");
		@(negedge clk);
		rx_nack = 1'b0;
		tx_en = 1'b1;
		foreach (rb[i]) begin
			@(negedge clk);
			tx_data = rb[i];
			run(CMD_READ, 8'h00, 1'(i == 0));
			chk(rd_data, rb[i], "read byte");
			chk({7'h0, m_ack}, {7'h0, i == 0}, "master ack");
		end
		chk(8'(mav_cnt), 8'h02, "ack frames");
		@(negedge clk);
		tx_en = 1'b0;
		run(CMD_RESET, 8'h00, 1'b0);
		chk({7'h0, lnk_rdy}, 8'h00, "idle reset");
		chk(addr_ptr, 8'h00, "pointer cleared");
		run(CMD_DISC, 8'h00, 1'b0);
		@(negedge clk);
		busy_req = 1'b1;
		@(negedge clk);
		busy_req = 1'b0;
		busy_done = 1'b1;
		@(negedge clk);
		busy_done = 1'b0;
		@(negedge clk);
		chk({7'h0, busy}, 8'h00, "busy ended");
		busy_req = 1'b1;
		repeat (2) @(negedge clk);
		busy_req = 1'b0;
		chk({7'h0, busy}, 8'h01, "busy on");
		n0 = rx_cnt;
		run(CMD_WRITE, 8'h55, 1'b0);
		chk(8'(rx_cnt - n0), 8'h00, "busy ignores frames");
		run(CMD_RESET, 8'h00, 1'b0);
		chk({7'h0, busy}, 8'h01, "short low while busy");
		run(CMD_DSCHG, 8'h00, 1'b0);
		chk({6'h0, busy, lnk_rdy}, 8'h00, "discharge reset");
		run(CMD_DISC, 8'h00, 1'b0);
		chk({6'h0, found, lnk_rdy}, 8'h03, "found again");
		end_sim();
	end
endmodule
`default_nettype wire
